// ### hw/dcc_top.sv
`timescale 1ns/1ps
`include "dcc_defines.svh"
module dcc_top
  import dcc_pkg::*;
#(
  parameter int TICK_CYCLES = `DCC_TICK_NS / `DCC_CLK_NS
)
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  input wire logic local_permit,
  input wire logic remote_permit,
  input wire logic open_enable,
  input wire logic close_enable,
  input wire logic operation_block,
  input wire logic pos_open_in,
  input wire logic pos_closed_in,
  input wire dcc_req_s req,
  output dcc_resp_s resp,
  output logic open_cmd_pulse,
  output logic close_cmd_pulse,
  output logic oper_pulse,
  output logic opened_out,
  output logic closed_out,
  output dcc_pos_e status,
  output logic status_event,
  output logic irq
);
  logic srst, next_srst, tick, dir, next_dir;
  logic [17:0] tick_cnt, next_tick_cnt;
  logic [1:0] pos_s;
  dcc_pos_e raw_pos, next_status;
  dcc_ms_t cmd_ms, sbo_ms, inter_ms, oper_ms;
  logic cmd_clr, sbo_clr, inter_clr, oper_clr;
  dcc_model_e model, next_model;
  logic forced, next_forced;
  dcc_ms_t oper_time, pulse_time, inter_time, sbo_time;
  dcc_ms_t next_oper_time, next_pulse_time, next_inter_time, next_sbo_time;
  dcc_state_e state, next_state;
  dcc_src_e src, next_src;
  dcc_resp_s next_resp;
  dcc_code_e gate;
  logic confirmed, pulse_end, enhanced;
  logic next_open, next_close, oper_set, next_oper, next_opened, next_closed, next_event;
  logic [31:0] op_count, next_count, next_rd;
  logic [4:0] irq_stat, next_stat, irq_mask, next_mask;
  logic cnt_clr, wr_ctrl, next_irq, ev_pos_err, ev_sbo, ev_ref;

  function automatic dcc_ms_t clamp_ms(input logic [31:0] v, input dcc_ms_t lo,
    input dcc_ms_t hi);
    dcc_ms_t r;
    r = (v > {16'h0000, hi}) ? hi : v[15:0];
    if (r < lo)
      r = lo;
    return r;
  endfunction : clamp_ms

  assign tick = (tick_cnt == 18'(TICK_CYCLES - 1));
  always_comb
  begin
    next_tick_cnt = (tick || srst) ? 18'h00000 : tick_cnt + 18'h00001;
    next_srst = wr_en && addr == `DCC_A_CTRL && wr_data[`DCC_CTRL_SRST];
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tick_cnt <= 18'h00000;
      srst <= 1'b0;
    end
    else if (clk_en)
    begin
      tick_cnt <= next_tick_cnt;
      srst <= next_srst;
    end
  end

  // the two position pins are synchronised before use.
  dcc_sync2 #(.W(2)) u_pos (.clock(clock), .reset_n(reset_n), .clk_en(clk_en),
    .d({pos_closed_in, pos_open_in}), .q(pos_s));

  dcc_ms_count u_cmd (.clock(clock), .reset_n(reset_n), .clk_en(clk_en),
    .clear(cmd_clr), .tick(tick), .count(cmd_ms));
  dcc_ms_count u_sbo (.clock(clock), .reset_n(reset_n), .clk_en(clk_en),
    .clear(sbo_clr), .tick(tick), .count(sbo_ms));
  dcc_ms_count u_inter (.clock(clock), .reset_n(reset_n), .clk_en(clk_en),
    .clear(inter_clr), .tick(tick), .count(inter_ms));
  dcc_ms_count u_oper (.clock(clock), .reset_n(reset_n), .clk_en(clk_en),
    .clear(oper_clr), .tick(tick), .count(oper_ms));

  // Position filter, operation pulse and operation counter.
  always_comb
  begin
    raw_pos = dcc_pos_e'(pos_s);
    inter_clr = srst || raw_pos != DCC_POS_INTER;
    next_status = status;
    if (raw_pos != DCC_POS_INTER)
      next_status = raw_pos;
    else if (inter_ms >= inter_time)
      next_status = DCC_POS_INTER;
    next_event = next_status != status;
    next_opened = next_status == DCC_POS_OFF;
    next_closed = next_status == DCC_POS_ON;
    oper_set = next_event && (next_opened || next_closed);
    oper_clr = oper_set || srst;
    next_oper = oper_pulse;
    if (srst)
      next_oper = 1'b0;
    else if (oper_set)
      next_oper = 1'b1;
    else if (oper_pulse && oper_ms >= `DCC_OPER_PULSE)
      next_oper = 1'b0;
    next_count = cnt_clr ? 32'h00000000 : op_count;
    if (oper_set && !oper_pulse && !srst)
      next_count = next_count + 32'h00000001;
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      status <= DCC_POS_INTER;
      status_event <= 1'b0;
      opened_out <= 1'b0;
      closed_out <= 1'b0;
      oper_pulse <= 1'b0;
      op_count <= 32'h00000000;
    end
    else if (clk_en)
    begin
      status <= next_status;
      status_event <= next_event;
      opened_out <= next_opened;
      closed_out <= next_closed;
      oper_pulse <= next_oper;
      op_count <= next_count;
    end
  end

  // Command sequencing.
  always_comb
  begin
    enhanced = model != DCC_DIRECT_NORMAL;
    confirmed = status == (dir ? DCC_POS_ON : DCC_POS_OFF);
    // early end after the least pulse.
    pulse_end = cmd_ms >= pulse_time || (confirmed && cmd_ms >= `DCC_MIN_PULSE);
    if (operation_block)
      gate = DCC_BLOCKED;
    else if (req.src == DCC_SRC_REMOTE ? !remote_permit : !local_permit)
      gate = DCC_NO_PERMIT;
    else if ((forced || !req.skip_check) && !(req.close ? close_enable : open_enable))
      gate = DCC_INTERLOCK;
    else
      gate = DCC_OK;
    next_state = state;
    next_dir = dir;
    next_src = src;
    next_resp = '0;
    cmd_clr = srst;
    sbo_clr = srst;
    ev_pos_err = 1'b0;
    ev_sbo = 1'b0;
    unique case (state)
      DCC_S_IDLE:
      begin
        if (req.valid)
        begin
          next_resp.valid = 1'b1;
          next_dir = req.close;
          next_src = req.src;
          if (gate != DCC_OK)
            next_resp.code = gate;
          else if (model == DCC_SBO_ENH && req.kind == DCC_REQ_SELECT)
          begin
            next_state = DCC_S_SELECTED;
            sbo_clr = 1'b1;
          end
          else if (model != DCC_SBO_ENH && req.kind == DCC_REQ_OPERATE)
          begin
            next_state = DCC_S_CMD;
            cmd_clr = 1'b1;
          end
          else
            next_resp.code = DCC_SEQUENCE;
        end
      end
      DCC_S_SELECTED:
      begin
        if (sbo_ms >= sbo_time)
        begin
          next_state = DCC_S_IDLE;
          next_resp = '{valid: 1'b1, code: DCC_SBO_TIMEOUT};
          ev_sbo = 1'b1;
        end
        else if (req.valid)
        begin
          next_resp.valid = 1'b1;
          if (req.kind == DCC_REQ_CANCEL)
            next_state = DCC_S_IDLE;
          else if (req.kind != DCC_REQ_OPERATE || req.src != src || req.close != dir)
            next_resp.code = DCC_SEQUENCE;
          else if (gate != DCC_OK)
            next_resp.code = gate;
          else
          begin
            next_state = DCC_S_CMD;
            cmd_clr = 1'b1;
          end
        end
      end
      DCC_S_CMD:
      begin
        if (operation_block)
          next_state = DCC_S_IDLE;
        else if (pulse_end)
        begin
          if (!enhanced)
            next_state = DCC_S_IDLE;
          else if (confirmed)
          begin
            next_state = DCC_S_IDLE;
            next_resp.valid = 1'b1;
          end
          else
            next_state = DCC_S_SUPERVISE;
        end
      end
      DCC_S_SUPERVISE:
      begin
        if (confirmed)
        begin
          next_state = DCC_S_IDLE;
          next_resp.valid = 1'b1;
        end
        else if (cmd_ms >= oper_time)
        begin
          next_state = DCC_S_IDLE;
          next_resp = '{valid: 1'b1, code: DCC_POS_INVALID};
          ev_pos_err = 1'b1;
        end
      end
    endcase
    // synchronous reset clears pulses and selection.
    if (srst)
    begin
      next_state = DCC_S_IDLE;
      next_resp = '0;
    end
    ev_ref = next_resp.valid && next_resp.code != DCC_OK && !ev_pos_err && !ev_sbo;
    next_open = next_state == DCC_S_CMD && !next_dir;
    next_close = next_state == DCC_S_CMD && next_dir;
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= DCC_S_IDLE;
      dir <= 1'b0;
      src <= DCC_SRC_LOCAL;
      resp <= '0;
      open_cmd_pulse <= 1'b0;
      close_cmd_pulse <= 1'b0;
    end
    else if (clk_en)
    begin
      state <= next_state;
      dir <= next_dir;
      src <= next_src;
      resp <= next_resp;
      open_cmd_pulse <= next_open;
      close_cmd_pulse <= next_close;
    end
  end

  // Register file and interrupt.
  always_comb
  begin
    wr_ctrl = wr_en && addr == `DCC_A_CTRL;
    cnt_clr = wr_ctrl && wr_data[`DCC_CTRL_CNT_CLR];
    next_model = model;
    next_forced = forced;
    next_oper_time = oper_time;
    next_pulse_time = pulse_time;
    next_inter_time = inter_time;
    next_sbo_time = sbo_time;
    next_mask = irq_mask;
    if (wr_en)
    begin
      case (addr)
        `DCC_A_CTRL:
        begin
          if (wr_data[1:0] != 2'h3)
            next_model = dcc_model_e'(wr_data[1:0]);
          next_forced = wr_data[`DCC_CTRL_FORCED];
        end
        `DCC_A_OPER_TIME: next_oper_time = clamp_ms(wr_data, `DCC_OPER_MIN, `DCC_OPER_MAX);
        `DCC_A_PULSE_TIME: next_pulse_time = clamp_ms(wr_data, `DCC_PULSE_MIN, `DCC_PULSE_MAX);
        `DCC_A_INTER_TIME: next_inter_time = clamp_ms(wr_data, `DCC_INTER_MIN, `DCC_INTER_MAX);
        `DCC_A_SBO_TIME: next_sbo_time = clamp_ms(wr_data, `DCC_SBO_MIN, `DCC_SBO_MAX);
        `DCC_A_IRQ_MASK: next_mask = wr_data[4:0];
        default: next_mask = irq_mask;
      endcase
    end
    // A read of the interrupt status register clears it, but a new event wins.
    next_stat = (rd_en && addr == `DCC_A_IRQ_STAT) ? 5'h00 : irq_stat;
    next_stat[`DCC_EV_STATUS] = next_stat[`DCC_EV_STATUS] | next_event;
    next_stat[`DCC_EV_OPER] = next_stat[`DCC_EV_OPER] | (oper_set && !oper_pulse);
    next_stat[`DCC_EV_POS_ERR] = next_stat[`DCC_EV_POS_ERR] | ev_pos_err;
    next_stat[`DCC_EV_SBO_TO] = next_stat[`DCC_EV_SBO_TO] | ev_sbo;
    next_stat[`DCC_EV_REFUSED] = next_stat[`DCC_EV_REFUSED] | ev_ref;
    next_irq = |(next_stat & next_mask);
    next_rd = 32'h00000000;
    if (rd_en)
    begin
      case (addr)
        `DCC_A_CTRL:
        begin
          next_rd[1:0] = model;
          next_rd[`DCC_CTRL_FORCED] = forced;
        end
        `DCC_A_OPER_TIME: next_rd = {16'h0000, oper_time};
        `DCC_A_PULSE_TIME: next_rd = {16'h0000, pulse_time};
        `DCC_A_INTER_TIME: next_rd = {16'h0000, inter_time};
        `DCC_A_SBO_TIME: next_rd = {16'h0000, sbo_time};
        `DCC_A_STATUS: next_rd = {20'h00000, state, raw_pos, 1'b0, closed_out, opened_out,
          oper_pulse, close_cmd_pulse, open_cmd_pulse, status};
        `DCC_A_COUNT: next_rd = op_count;
        `DCC_A_IRQ_STAT: next_rd = {27'h0000000, irq_stat};
        `DCC_A_IRQ_MASK: next_rd = {27'h0000000, irq_mask};
        default: next_rd = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      model <= DCC_DIRECT_NORMAL;
      forced <= 1'b1;
      oper_time <= `DCC_OPER_DEF;
      pulse_time <= `DCC_PULSE_DEF;
      inter_time <= `DCC_INTER_DEF;
      sbo_time <= `DCC_SBO_DEF;
      irq_mask <= 5'h00;
      irq_stat <= 5'h00;
      irq <= 1'b0;
      rd_data <= 32'h00000000;
    end
    else if (clk_en)
    begin
      model <= next_model;
      forced <= next_forced;
      oper_time <= next_oper_time;
      pulse_time <= next_pulse_time;
      inter_time <= next_inter_time;
      sbo_time <= next_sbo_time;
      irq_mask <= next_mask;
      irq_stat <= next_stat;
      irq <= next_irq;
      rd_data <= next_rd;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n || !clk_en);

  chk_local_gate: assert property (state == DCC_S_IDLE && req.valid && !srst
    && req.src == DCC_SRC_LOCAL && !local_permit |=> resp.valid && resp.code != DCC_OK)
    else $error("local request accepted without permission");
  chk_remote_gate: assert property (state == DCC_S_IDLE && req.valid && !srst
    && req.src == DCC_SRC_REMOTE && !remote_permit |=> resp.code == DCC_NO_PERMIT
    || resp.code == DCC_BLOCKED)
    else $error("remote request accepted without permission");
  chk_open_ilk: assert property ($rose(open_cmd_pulse) && forced |-> $past(open_enable))
    else $error("open pulse without open enable");
  chk_close_ilk: assert property ($rose(close_cmd_pulse) && forced |-> $past(close_enable))
    else $error("close pulse without close enable");
  chk_block_quiet: assert property (operation_block |=> !open_cmd_pulse && !close_cmd_pulse)
    else $error("command pulse while blocked");
  chk_forced_check: assert property (state == DCC_S_IDLE && req.valid && forced && !srst
    && req.skip_check && !req.close && !open_enable |=> !open_cmd_pulse)
    else $error("skip attribute bypassed forced check");
  chk_pulse_len: assert property ((open_cmd_pulse || close_cmd_pulse)
    && cmd_ms >= pulse_time |=> !open_cmd_pulse && !close_cmd_pulse)
    else $error("command pulse exceeds pulse duration");
  chk_min_pulse: assert property ($fell(open_cmd_pulse || close_cmd_pulse)
    && !$past(operation_block) && !$past(srst)
    |-> $past(cmd_ms) >= `DCC_MIN_PULSE || $past(cmd_ms) >= $past(pulse_time))
    else $error("command pulse shorter than least duration");
  chk_oper_err: assert property (state == DCC_S_SUPERVISE && !confirmed && !srst
    && cmd_ms >= oper_time |=> resp.valid && resp.code == DCC_POS_INVALID)
    else $error("missing invalid position report");
  chk_sbo_expire: assert property (state == DCC_S_SELECTED && sbo_ms >= sbo_time
    |=> state == DCC_S_IDLE && !open_cmd_pulse && !close_cmd_pulse)
    else $error("selection survived its timeout");
  chk_inter_time: assert property (raw_pos == DCC_POS_INTER && inter_ms >= inter_time
    |=> status == DCC_POS_INTER)
    else $error("intermediate not reported after filter time");
  chk_filtered: assert property (opened_out |-> status == DCC_POS_OFF && !closed_out)
    else $error("opened output without settled open position");
  chk_oper_width: assert property (oper_pulse && oper_ms < `DCC_OPER_PULSE && !srst
    |=> oper_pulse)
    else $error("operation pulse ended early");
  chk_cnt_step: assert property ($rose(oper_pulse) && !$past(cnt_clr)
    |-> op_count == $past(op_count) + 32'h00000001)
    else $error("operation counter missed an operation");
  chk_event_change: assert property (status != $past(status) |-> status_event)
    else $error("status change without event");
  chk_srst_clear: assert property (srst |=> state == DCC_S_IDLE && !open_cmd_pulse
    && !oper_pulse)
    else $error("synchronous reset left state behind");
  chk_decode: assert property (pos_s == 2'h1 |=> status == DCC_POS_OFF)
    else $error("open contact alone not decoded as off");
  chk_model_direct: assert property (model == DCC_DIRECT_NORMAL && state == DCC_S_IDLE
    && req.valid && req.kind == DCC_REQ_SELECT |=> state == DCC_S_IDLE)
    else $error("selection taken in direct model");
  cov_direct_op: cover property (state == DCC_S_IDLE ##1 state == DCC_S_CMD);
  cov_sbo_op: cover property (state == DCC_S_SELECTED ##1 state == DCC_S_CMD);
  cov_pos_err: cover property (resp.valid && resp.code == DCC_POS_INVALID);
  cov_sbo_to: cover property (resp.valid && resp.code == DCC_SBO_TIMEOUT);
endmodule : dcc_top

// ### hw/dcc_defines.svh
`ifndef DCC_DEFINES_SVH
`define DCC_DEFINES_SVH
// Clock period in ns and time base period in ns (1 ms).
`define DCC_CLK_NS 5
`define DCC_TICK_NS 1000000
// Register byte addresses.
`define DCC_A_CTRL 8'h00
`define DCC_A_OPER_TIME 8'h04
`define DCC_A_PULSE_TIME 8'h08
`define DCC_A_INTER_TIME 8'h0c
`define DCC_A_SBO_TIME 8'h10
`define DCC_A_STATUS 8'h14
`define DCC_A_COUNT 8'h18
`define DCC_A_IRQ_STAT 8'h1c
`define DCC_A_IRQ_MASK 8'h20
// Control register fields.
`define DCC_CTRL_FORCED 2
`define DCC_CTRL_CNT_CLR 3
`define DCC_CTRL_SRST 4
// Event bits of the interrupt status and mask registers.
`define DCC_EV_STATUS 0
`define DCC_EV_OPER 1
`define DCC_EV_POS_ERR 2
`define DCC_EV_SBO_TO 3
`define DCC_EV_REFUSED 4
// Setting limits and defaults in ms; one tick is one ms.
`define DCC_OPER_MIN 16'h000a
`define DCC_OPER_MAX 16'hea60
`define DCC_OPER_DEF 16'h2710
`define DCC_PULSE_MIN 16'h0064
`define DCC_PULSE_MAX 16'hea60
`define DCC_PULSE_DEF 16'h03e8
`define DCC_INTER_MIN 16'h0014
`define DCC_INTER_MAX 16'hea60
`define DCC_INTER_DEF 16'h2710
`define DCC_SBO_MIN 16'h03e8
`define DCC_SBO_MAX 16'h4e20
`define DCC_SBO_DEF 16'h1388
// Least command pulse on confirmed switching, and operation pulse, in ms.
`define DCC_MIN_PULSE 16'h03e8
`define DCC_OPER_PULSE 16'h0096
`endif

// ### hw/dcc_pkg.sv
package dcc_pkg;
  typedef logic [15:0] dcc_ms_t;
  typedef enum logic [1:0] {DCC_POS_INTER, DCC_POS_OFF, DCC_POS_ON, DCC_POS_BAD} dcc_pos_e;
  typedef enum logic [1:0] {DCC_DIRECT_NORMAL, DCC_DIRECT_ENH, DCC_SBO_ENH} dcc_model_e;
  typedef enum logic [1:0] {DCC_REQ_SELECT, DCC_REQ_OPERATE, DCC_REQ_CANCEL} dcc_kind_e;
  typedef enum logic {DCC_SRC_LOCAL, DCC_SRC_REMOTE} dcc_src_e;
  typedef enum logic [2:0] {DCC_OK, DCC_BLOCKED, DCC_NO_PERMIT, DCC_INTERLOCK, DCC_SEQUENCE,
    DCC_POS_INVALID, DCC_SBO_TIMEOUT} dcc_code_e;
  typedef enum logic [1:0] {DCC_S_IDLE, DCC_S_SELECTED, DCC_S_CMD, DCC_S_SUPERVISE} dcc_state_e;
  typedef struct packed {
    logic valid;
    dcc_src_e src;
    dcc_kind_e kind;
    logic close;
    logic skip_check;
  } dcc_req_s;
  typedef struct packed {
    logic valid;
    dcc_code_e code;
  } dcc_resp_s;
endpackage : dcc_pkg

// ### hw/dcc_sync2.sv
`timescale 1ns/1ps
module dcc_sync2 #(
  parameter int W = 2
)
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta <= '0;
      q <= '0;
    end
    else if (clk_en)
    begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : dcc_sync2

// ### hw/dcc_ms_count.sv
`timescale 1ns/1ps
module dcc_ms_count
  import dcc_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic clear,
  input wire logic tick,
  output dcc_ms_t count
);
  dcc_ms_t next_count;

  // Counts elapsed ms since the last clear and saturates at full scale.
  always_comb
  begin
    next_count = count;
    if (clear)
      next_count = 16'h0000;
    else if (tick && count != 16'hffff)
      next_count = count + 16'h0001;
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      count <= 16'h0000;
    else if (clk_en)
      count <= next_count;
  end
endmodule : dcc_ms_count

// ### sim/dcc_switch_model.sv
`timescale 1ns/1ps
module dcc_switch_model #(
  parameter int DELAY = 40
)
(
  input wire logic clock,
  input wire logic open_cmd,
  input wire logic close_cmd,
  input wire logic stuck,
  input wire logic drop,
  output logic pos_open_in,
  output logic pos_closed_in
);
  int n = 0;
  logic closed = 1'h1;
  // The drive moves once a command has been held long enough.
  always @(posedge clock)
  begin
    n <= (open_cmd || close_cmd) ? n + 1 : 0;
    if (n == DELAY && !stuck)
      closed <= close_cmd;
  end
  assign pos_open_in = !drop && !closed;
  assign pos_closed_in = !drop && closed;
endmodule : dcc_switch_model

// ### sim/dcc_top_tb.sv
`timescale 1ns/1ps
`include "dcc_defines.svh"
module dcc_top_tb;
  import dcc_pkg::*;
  logic clock = 1'h0, reset_n = 1'h0, clk_en = 1'h1, wr_en = 1'h0, rd_en = 1'h0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wr_data = 32'h0, rd_data, seed = 32'h4afa, d;
  logic local_permit = 1'h1, remote_permit = 1'h1, open_enable = 1'h1, close_enable = 1'h1;
  logic operation_block = 1'h0, stuck = 1'h0, drop = 1'h0, pos_open_in, pos_closed_in;
  logic open_cmd_pulse, close_cmd_pulse, oper_pulse, opened_out, closed_out, status_event, irq;
  dcc_req_s req = '0;
  dcc_resp_s resp;
  dcc_pos_e status;
  int n_mismatch = 0, total_checks = 0, exp_cnt = 1, exp_closed = 1, forced = 1, hi, ev = 0;
  int olen = 0, olast = 0;
  dcc_top #(.TICK_CYCLES(4)) dut_u (.clock(clock), .reset_n(reset_n), .clk_en(clk_en),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .local_permit(local_permit), .remote_permit(remote_permit), .open_enable(open_enable),
    .close_enable(close_enable), .operation_block(operation_block), .pos_open_in(pos_open_in),
    .pos_closed_in(pos_closed_in), .req(req), .resp(resp), .open_cmd_pulse(open_cmd_pulse),
    .close_cmd_pulse(close_cmd_pulse), .oper_pulse(oper_pulse), .opened_out(opened_out),
    .closed_out(closed_out), .status(status), .status_event(status_event), .irq(irq));
  dcc_switch_model #(.DELAY(40)) sw_u (.clock(clock), .open_cmd(open_cmd_pulse),
    .close_cmd(close_cmd_pulse), .stuck(stuck), .drop(drop), .pos_open_in(pos_open_in),
    .pos_closed_in(pos_closed_in));
  always #2.5 clock = ~clock;
  always @(posedge clock)
    if (status_event === 1'h1)
      ev <= ev + 1;
  // Length of the last finished operation pulse in clock cycles.
  always @(posedge clock)
    olen <= (oper_pulse === 1'h1) ? olen + 1 : 0;
  always @(posedge clock)
    if (oper_pulse !== 1'h1 && olen != 0)
      olast <= olen;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  // Expected answer to a direct operate request built from the gate inputs in s.
  function automatic int exp_code(input logic [31:0] s, input int f);
    if (&s[9:8])
      return 1;
    if (s[10] ? !(|s[3:2]) : !(|s[1:0]))
      return 2;
    if ((f != 0 || !s[12]) && !(s[11] ? |s[7:6] : |s[5:4]))
      return 3;
    return 0;
  endfunction : exp_code
  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    addr <= a;
    wr_data <= v;
    wr_en <= 1'h1;
    @(posedge clock);
    wr_en <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'h1;
    @(posedge clock);
    rd_en <= 1'h0;
    #1 v = rd_data;
  endtask : rd
  task automatic send(input dcc_kind_e k, input logic s, input logic c, input logic sk);
    @(posedge clock);
    req <= '{1'h1, dcc_src_e'(s), k, c, sk};
    @(posedge clock);
    req.valid <= 1'h0;
    #1;
  endtask : send
  // Waits for the next response, or while any pulse runs, counting command cycles.
  task automatic wait_for(input logic for_resp, output int h);
    int k;
    h = 0;
    k = 0;
    while (k < 8000 && (for_resp ? resp.valid !== 1'h1
      : (open_cmd_pulse | close_cmd_pulse | oper_pulse) !== 1'h0))
    begin
      @(posedge clock);
      #1 h += (open_cmd_pulse | close_cmd_pulse);
      k++;
    end
    // A wait that runs out ends the run as a failure.
    if (k == 8000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  endtask : wait_for
  initial
  begin
    #300000;
    n_mismatch++;
    report_and_stop();
  end
  initial
  begin
    repeat (3) @(posedge clock);
    reset_n <= 1'h1;
    rd(`DCC_A_CTRL, d);
    check(d, 32'h4);
    rd(`DCC_A_PULSE_TIME, d);
    check(d, 32'h3e8);
    rd(8'h24, d);
    check(d, 32'h0);
    wr(`DCC_A_PULSE_TIME, 32'h64);
    wr(`DCC_A_IRQ_MASK, 32'h10);
    clk_en <= 1'h0;
    wr(`DCC_A_IRQ_MASK, 32'h1f);
    clk_en <= 1'h1;
    rd(`DCC_A_IRQ_MASK, d);
    check(d, 32'h10);
    wait_for(1'h0, hi);
    for (int i = 0; i < 24; i++)
    begin
      seed = xs(seed);
      if (i == 12)
        wr(`DCC_A_CTRL, 32'h0);
      forced = (i < 12);
      @(posedge clock);
      local_permit <= |seed[1:0];
      remote_permit <= |seed[3:2];
      open_enable <= |seed[5:4];
      close_enable <= |seed[7:6];
      operation_block <= &seed[9:8];
      send(DCC_REQ_OPERATE, seed[10], seed[11], seed[12]);
      check(32'(resp.code), exp_code(seed, forced));
      if (exp_code(seed, forced) == 0 && seed[11] != exp_closed)
        exp_cnt++;
      if (exp_code(seed, forced) == 0)
        exp_closed = seed[11];
      wait_for(1'h0, hi);
      check(32'(opened_out), 32'(!exp_closed));
      check(32'(closed_out), exp_closed);
      check(32'(status), exp_closed ? 2 : 1);
    end
    rd(`DCC_A_COUNT, d);
    check(d, exp_cnt);
    check(ev, exp_cnt);
    check(32'(olast >= 596 && olast <= 604), 1);
    wr(`DCC_A_CTRL, 32'h8);
    rd(`DCC_A_COUNT, d);
    check(d, 32'h0);
    operation_block <= 1'h1;
    send(DCC_REQ_OPERATE, 1'h0, 1'h0, 1'h0);
    check(32'(resp.code), 1);
    @(posedge clock);
    #1 check(32'(irq), 1);
    rd(`DCC_A_IRQ_STAT, d);
    check(32'(d[4]), 1);
    @(posedge clock);
    #1 check(32'(irq), 0);
    operation_block <= 1'h0;
    local_permit <= 1'h1;
    open_enable <= 1'h1;
    close_enable <= 1'h1;
    send(DCC_REQ_SELECT, 1'h0, 1'h0, 1'h0);
    check(32'(resp.code), 4);
    wr(`DCC_A_PULSE_TIME, 32'h7d0);
    send(DCC_REQ_OPERATE, 1'h0, exp_closed == 0, 1'h0);
    wait_for(1'h0, hi);
    check(32'(hi >= 3995 && hi <= 4001), 1);
    exp_closed = !exp_closed;
    wr(`DCC_A_PULSE_TIME, 32'h64);
    wr(`DCC_A_CTRL, 32'h5);
    wr(`DCC_A_OPER_TIME, 32'ha);
    stuck <= 1'h1;
    send(DCC_REQ_OPERATE, 1'h0, !exp_closed, 1'h0);
    check(32'(resp.code), 0);
    @(posedge clock);
    #1 wait_for(1'h1, hi);
    check(32'(resp.code), 5);
    check(32'(hi >= 396 && hi <= 404), 1);
    stuck <= 1'h0;
    wr(`DCC_A_CTRL, 32'h6);
    wr(`DCC_A_SBO_TIME, 32'h3e8);
    send(DCC_REQ_OPERATE, 1'h0, 1'h1, 1'h0);
    check(32'(resp.code), 4);
    send(DCC_REQ_SELECT, 1'h0, 1'h1, 1'h0);
    check(32'(resp.code), 0);
    @(posedge clock);
    #1 wait_for(1'h1, hi);
    check(32'(resp.code), 6);
    check(hi, 0);
    send(DCC_REQ_SELECT, 1'h0, 1'h1, 1'h0);
    wr(`DCC_A_CTRL, 32'h16);
    rd(`DCC_A_STATUS, d);
    check(32'(d[11:10]), 0);
    check(32'(d[1:0]), exp_closed ? 2 : 1);
    wr(`DCC_A_INTER_TIME, 32'h14);
    drop <= 1'h1;
    repeat (40) @(posedge clock);
    #1 check(32'(status), exp_closed ? 2 : 1);
    repeat (60) @(posedge clock);
    #1 check(32'(status), 0);
    report_and_stop();
  end
endmodule : dcc_top_tb
